// ===== verilog/rx_pcs_map.vh
// register offsets, fields, reset values and codes of the receive back end
`ifndef RX_PCS_MAP_VH
`define RX_PCS_MAP_VH

// register byte offsets (one 32-bit word each)
`define OFS_CTRL       5'h00
`define OFS_PATTERN    5'h04
`define OFS_STATUS     5'h08
`define OFS_IRQ_STAT   5'h0c
`define OFS_IRQ_MASK   5'h10

// control register fields
`define CTRL_FABCLK    0
`define CTRL_BOND_LO   1
`define CTRL_BOND_HI   2
`define CTRL_RMFIFO    3
`define CTRL_W         4
`define CTRL_RST       4'h0

// bonding modes
`define BOND_NONE      2'h0
`define BOND_X4        2'h1
`define BOND_X8        2'h2

// ordering pattern register: [7:0] byte, [8] control flag
`define PAT_K          8
`define PAT_W          9
`define PAT_RST        9'h1bc

// fifo clock source codes
`define CLK_FABRIC     2'h0
`define CLK_RECOV      2'h1
`define CLK_TXLOCAL    2'h2
`define CLK_CMU        2'h3

// status register fields
`define STAT_SRC_LO    0
`define STAT_SRC_HI    1
`define STAT_MASTER    2
`define STAT_FULL      3
`define STAT_EMPTY     4
`define STAT_FOUND_LO  8

// interrupt bits
`define IRQ_CODE       0
`define IRQ_DISP       1
`define IRQ_OVF        2
`define IRQ_FOUND      3
`define IRQ_W          4
`define IRQ_RST        4'h0

`endif

// ===== verilog/rx_8b10b_lane_decoder.v
// one-byte 8b/10b decoder with disparity check, purely combinational
`timescale 1ns/1ps
`default_nettype none

module rx_8b10b_lane_decoder (
    input  wire [9:0] code,
    input  wire       rdNegIn,
    output reg  [7:0] data,
    output wire       ctrl,
    output wire       codeErr,
    output wire       dispErr,
    output wire       rdNegOut
);

    // a is code[0] and goes first; rows read abcdei and fghj
    wire [5:0] s6 = {code[0], code[1], code[2], code[3], code[4], code[5]};
    wire [3:0] s4 = {code[6], code[7], code[8], code[9]};
    wire       k28 = (s6 == 6'h0f) || (s6 == 6'h30);
    wire [3:0] f4 = (s6 == 6'h30) ? ~s4 : s4; // k28 with rd+ flips fghj
    wire       a7 = (s4 == 4'h7) || (s4 == 4'h8);

    reg  [4:0] d5;
    reg        ok6;
    reg  [2:0] d3;
    reg        ok4;

    function [2:0] pop6;
        input [5:0] v;
        integer i;
        begin
            pop6 = 3'h0;
            for (i = 0; i < 6; i = i + 1) begin
                pop6 = pop6 + {2'h0, v[i]};
            end
        end
    endfunction

    // 6b to 5b lookup
    always @* begin
        ok6 = 1'b1;
        case (s6)
            6'h27, 6'h18: d5 = 5'h00;
            6'h1d, 6'h22: d5 = 5'h01;
            6'h2d, 6'h12: d5 = 5'h02;
            6'h31:        d5 = 5'h03;
            6'h35, 6'h0a: d5 = 5'h04;
            6'h29:        d5 = 5'h05;
            6'h19:        d5 = 5'h06;
            6'h38, 6'h07: d5 = 5'h07;
            6'h39, 6'h06: d5 = 5'h08;
            6'h25:        d5 = 5'h09;
            6'h15:        d5 = 5'h0a;
            6'h34:        d5 = 5'h0b;
            6'h0d:        d5 = 5'h0c;
            6'h2c:        d5 = 5'h0d;
            6'h1c:        d5 = 5'h0e;
            6'h17, 6'h28: d5 = 5'h0f;
            6'h1b, 6'h24: d5 = 5'h10;
            6'h23:        d5 = 5'h11;
            6'h13:        d5 = 5'h12;
            6'h32:        d5 = 5'h13;
            6'h0b:        d5 = 5'h14;
            6'h2a:        d5 = 5'h15;
            6'h1a:        d5 = 5'h16;
            6'h3a, 6'h05: d5 = 5'h17;
            6'h33, 6'h0c: d5 = 5'h18;
            6'h26:        d5 = 5'h19;
            6'h16:        d5 = 5'h1a;
            6'h36, 6'h09: d5 = 5'h1b;
            6'h0e:        d5 = 5'h1c;
            6'h2e, 6'h11: d5 = 5'h1d;
            6'h1e, 6'h21: d5 = 5'h1e;
            6'h2b, 6'h14: d5 = 5'h1f;
            6'h0f, 6'h30: d5 = 5'h1c;
            default: begin
                d5 = 5'h00;
                ok6 = 1'b0;
            end
        endcase
    end

    // 4b to 3b lookup
    always @* begin
        ok4 = 1'b1;
        case (f4)
            4'hb, 4'h4: d3 = 3'h0;
            4'h9:       d3 = 3'h1;
            4'h5:       d3 = 3'h2;
            4'hc, 4'h3: d3 = 3'h3;
            4'hd, 4'h2: d3 = 3'h4;
            4'ha:       d3 = 3'h5;
            4'h6:       d3 = 3'h6;
            4'he, 4'h1: d3 = 3'h7;
            4'h7, 4'h8: d3 = 3'h7;
            default: begin
                d3 = 3'h0;
                ok4 = 1'b0;
            end
        endcase
        data = {d3, d5};
    end

    // control groups: k28.y and the four k.x.7 with alternate 7
    wire kx7 = (d5 == 5'h17) || (d5 == 5'h1b) || (d5 == 5'h1d) ||
               (d5 == 5'h1e);
    wire a7ok = (d5 == 5'h11) || (d5 == 5'h12) || (d5 == 5'h14) ||
                (d5 == 5'h0b) || (d5 == 5'h0d) || (d5 == 5'h0e);
    assign ctrl = ok6 & (k28 | (a7 & kx7));
    assign codeErr = ~ok6 | ~ok4 | (a7 & ~k28 & ~kx7 & ~a7ok);

    // disparity of each sub-block against the running value
    wire [2:0] p6 = pop6(s6);
    wire [2:0] p4 = pop6({2'h0, s4});
    wire pos6 = (p6 > 3'h3) || (s6 == 6'h07);
    wire neg6 = (p6 < 3'h3) || (s6 == 6'h38);
    wire rdMid = pos6 ? 1'b0 : (neg6 ? 1'b1 : rdNegIn);
    wire pos4 = (p4 > 3'h2) || (s4 == 4'h3);
    wire neg4 = (p4 < 3'h2) || (s4 == 4'hc);
    wire bad6 = rdNegIn ? ((p6 < 3'h3) || (s6 == 6'h07))
                        : ((p6 > 3'h3) || (s6 == 6'h38));
    wire bad4 = rdMid ? ((p4 < 3'h2) || (s4 == 4'h3))
                      : ((p4 > 3'h2) || (s4 == 4'hc));
    assign dispErr = bad6 | bad4;
    assign rdNegOut = pos4 ? 1'b0 : (neg4 ? 1'b1 : rdMid);

endmodule

`default_nettype wire

// ===== verilog/rx_pcs_decode_order_fifo.v
// receive back end: 8b/10b decode, byte ordering, phase fifo, bus slave
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rx_pcs_map.vh"

module rx_pcs_decode_order_fifo #(
    parameter NUM_CH  = 1,
    parameter BYTES   = 2,
    parameter FIFO_AW = 3
) (
    input  wire                      clk_sys,
    input  wire                      sys_rst,
    input  wire [4:0]                avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [31:0]               avs_writedata,
    input  wire [3:0]                avs_byteenable,
    output reg  [31:0]               avs_readdata,
    output wire                      avs_waitrequest,
    output wire                      irq,
    input  wire [NUM_CH*BYTES*10-1:0] codeIn,
    input  wire                      codeValid,
    input  wire [NUM_CH-1:0]         orderRestart,
    output wire [NUM_CH-1:0]         orderFound,
    input  wire                      readReady,
    output reg                       dataValid,
    output wire [NUM_CH*BYTES*8-1:0] rxData,
    output wire [NUM_CH*BYTES-1:0]   ctrlDetect,
    output wire [NUM_CH*BYTES-1:0]   codeErrDetect,
    output wire [NUM_CH*BYTES-1:0]   dispErr,
    output wire [NUM_CH*BYTES-1:0]   runningDispNeg,
    output wire                      fifoError
);

    localparam LANES = NUM_CH * BYTES;
    localparam UW    = 12;              // rdNeg, disp, err, ctrl, data
    localparam CW    = BYTES * UW;
    localparam FW    = LANES * UW;
    localparam DEPTH = 1 << FIFO_AW;

    // ---------------- register bus ----------------
    reg  [`CTRL_W-1:0] ctrlReg;
    reg  [`PAT_W-1:0]  patReg;
    reg  [`IRQ_W-1:0]  irqStat;
    reg  [`IRQ_W-1:0]  irqMask;
    reg                ack;
    reg  [1:0]         clkSrc;
    reg                cmuMaster;
    reg  [31:0]        next_readdata;
    wire [`IRQ_W-1:0]  irqEvent;
    wire               fifoFull;
    wire               fifoEmpty;

    wire req    = avs_read | avs_write;
    wire wrStb  = avs_write & ack;
    wire [4:0] ofs = {avs_address[4:2], 2'b00};

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[8*i +: 8] = wd[8*i +: 8];
                end
            end
        end
    endfunction

    wire [31:0] ctrlNew = merge({28'h0, ctrlReg}, avs_writedata,
                                avs_byteenable);
    wire [31:0] patNew  = merge({23'h0, patReg}, avs_writedata,
                                avs_byteenable);
    wire [31:0] maskNew = merge({28'h0, irqMask}, avs_writedata,
                                avs_byteenable);
    wire [`IRQ_W-1:0] irqClr = (wrStb && ofs == `OFS_IRQ_STAT) ?
        (avs_writedata[`IRQ_W-1:0] & {`IRQ_W{avs_byteenable[0]}}) :
        {`IRQ_W{1'b0}};

    // one wait cycle on every access, then the answer
    assign avs_waitrequest = req & ~ack;

    // read multiplexer, unmapped words read zero
    always @* begin
        case (ofs)
            `OFS_CTRL:     next_readdata = {28'h0, ctrlReg};
            `OFS_PATTERN:  next_readdata = {23'h0, patReg};
            `OFS_STATUS: begin
                next_readdata = 32'h0;
                next_readdata[`STAT_SRC_HI:`STAT_SRC_LO] = clkSrc;
                next_readdata[`STAT_MASTER] = cmuMaster;
                next_readdata[`STAT_FULL]   = fifoFull;
                next_readdata[`STAT_EMPTY]  = fifoEmpty;
                next_readdata[`STAT_FOUND_LO +: NUM_CH] = orderFound;
            end
            `OFS_IRQ_STAT: next_readdata = {28'h0, irqStat};
            `OFS_IRQ_MASK: next_readdata = {28'h0, irqMask};
            default:       next_readdata = 32'h0;
        endcase
    end

    // register writes, handshake and sticky interrupt bits
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
            ctrlReg      <= `CTRL_RST;
            patReg       <= `PAT_RST;
            irqMask      <= `IRQ_RST;
            irqStat      <= `IRQ_RST;
        end else begin
            ack <= req & ~ack;
            if (avs_read && !ack) begin
                avs_readdata <= next_readdata;
            end
            if (wrStb && ofs == `OFS_CTRL) begin
                ctrlReg <= ctrlNew[`CTRL_W-1:0];
            end
            if (wrStb && ofs == `OFS_PATTERN) begin
                patReg <= patNew[`PAT_W-1:0];
            end
            if (wrStb && ofs == `OFS_IRQ_MASK) begin
                irqMask <= maskNew[`IRQ_W-1:0];
            end
            irqStat <= (irqStat & ~irqClr) | irqEvent; // set beats clear
        end
    end

    assign irq = |(irqStat & irqMask);

    // ---------------- fifo clock choice ----------------
    // only one clock exists here; the choice is reported in status
    always @* begin
        cmuMaster = 1'b0;
        if (ctrlReg[`CTRL_FABCLK]) begin
            clkSrc = `CLK_FABRIC;
        end else if (ctrlReg[`CTRL_BOND_HI:`CTRL_BOND_LO] != `BOND_NONE) begin
            clkSrc = `CLK_CMU;
            cmuMaster = (ctrlReg[`CTRL_BOND_HI:`CTRL_BOND_LO] == `BOND_X8);
        end else if (ctrlReg[`CTRL_RMFIFO]) begin
            clkSrc = `CLK_TXLOCAL;
        end else begin
            clkSrc = `CLK_RECOV;
        end
    end

    // ---------------- restart input synchroniser ----------------
    reg  [NUM_CH-1:0] rs1;
    reg  [NUM_CH-1:0] rs2;
    reg  [NUM_CH-1:0] rs3;
    reg  [NUM_CH-1:0] rsLvl;
    wire [NUM_CH-1:0] rsRise = rs2 & rs3 & ~rsLvl;

    // level moves only while the second and third stage agree
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            rs1   <= {NUM_CH{1'b0}};
            rs2   <= {NUM_CH{1'b0}};
            rs3   <= {NUM_CH{1'b0}};
            rsLvl <= {NUM_CH{1'b0}};
        end else begin
            rs1   <= orderRestart;
            rs2   <= rs1;
            rs3   <= rs2;
            rsLvl <= (rs2 & rs3) | (rsLvl & (rs2 ^ rs3));
        end
    end

    // ---------------- lane decoders ----------------
    wire [LANES-1:0]    rdIn;
    wire [LANES-1:0]    rdOut;
    wire [LANES-1:0]    laneCodeErr;
    wire [LANES-1:0]    laneDispErr;
    wire [FW-1:0]       units;
    wire [FW-1:0]       fifoIn;
    wire [NUM_CH-1:0]   rdNow;
    reg  [NUM_CH-1:0]   foundPrev;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            wire [7:0] dByte;
            wire       kFlag;
            // running disparity chains low byte first within a channel
            if (g % BYTES == 0) begin : first
                assign rdIn[g] = rdNow[g / BYTES];
            end else begin : chained
                assign rdIn[g] = rdOut[g - 1];
            end
            rx_8b10b_lane_decoder dec (
                .code     (codeIn[10*g +: 10]),
                .rdNegIn  (rdIn[g]),
                .data     (dByte),
                .ctrl     (kFlag),
                .codeErr  (laneCodeErr[g]),
                .dispErr  (laneDispErr[g]),
                .rdNegOut (rdOut[g])
            );
            // error pair: code-only gives 01, any disparity gives 11
            assign units[UW*g +: UW] = {rdOut[g], laneDispErr[g],
                laneCodeErr[g] | laneDispErr[g], kFlag, dByte};
        end

        // ---------------- byte ordering per channel ----------------
        for (g = 0; g < NUM_CH; g = g + 1) begin : chan
            reg           searching;
            reg           found;
            reg           swap;
            reg           rdState;
            reg  [UW-1:0] prevHi;
            wire [CW-1:0] cur = units[CW*g +: CW];
            wire [CW-1:0] ordered;
            wire          hiMatch;
            if (BYTES == 2) begin : two
                // swap realigns by one byte using the held high byte
                assign ordered = swap ? {cur[UW-1:0], prevHi} : cur;
                assign hiMatch = (ordered[UW +: `PAT_W] == patReg);
            end else begin : one
                assign ordered = cur;
                assign hiMatch = 1'b0;
            end
            wire loMatch = (ordered[`PAT_W-1:0] == patReg);

            always @(posedge clk_sys) begin
                if (sys_rst) begin
                    searching <= 1'b1;
                    found     <= 1'b0;
                    swap      <= 1'b0;
                    rdState   <= 1'b1;
                    prevHi    <= {UW{1'b0}};
                end else begin
                    if (rsRise[g]) begin
                        searching <= 1'b1;
                        found     <= 1'b0;
                        swap      <= 1'b0;
                    end else if (codeValid && searching) begin
                        if (loMatch) begin
                            found     <= 1'b1;
                            searching <= 1'b0;
                        end else if (hiMatch) begin
                            swap <= ~swap;
                        end
                    end
                    if (codeValid) begin
                        prevHi  <= cur[CW-1 -: UW];
                        rdState <= rdOut[g*BYTES + BYTES - 1];
                    end
                end
            end
            assign rdNow[g] = rdState;
            assign orderFound[g] = found;
            assign fifoIn[CW*g +: CW] = ordered;
        end
    endgenerate

    // edge memory for the found event
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            foundPrev <= {NUM_CH{1'b0}};
        end else begin
            foundPrev <= orderFound;
        end
    end

    // ---------------- phase compensation fifo ----------------
    reg  [FW-1:0]      mem [0:DEPTH-1];
    reg  [FIFO_AW:0]   wPtr;
    reg  [FIFO_AW:0]   rPtr;
    reg  [FW-1:0]      outWord;

    assign fifoEmpty = (wPtr == rPtr);
    assign fifoFull  = (wPtr[FIFO_AW] != rPtr[FIFO_AW]) &&
                       (wPtr[FIFO_AW-1:0] == rPtr[FIFO_AW-1:0]);
    assign fifoError = fifoFull | fifoEmpty;
    wire push = codeValid & ~fifoFull;
    wire pop  = readReady & ~fifoEmpty;

    // storage, write side
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wPtr[FIFO_AW-1:0]] <= fifoIn;
        end
    end

    // pointers and registered output word
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wPtr      <= {(FIFO_AW+1){1'b0}};
            rPtr      <= {(FIFO_AW+1){1'b0}};
            outWord   <= {FW{1'b0}};
            dataValid <= 1'b0;
        end else begin
            dataValid <= pop;
            if (push) begin
                wPtr <= wPtr + 1'b1;
            end
            if (pop) begin
                outWord <= mem[rPtr[FIFO_AW-1:0]];
                rPtr    <= rPtr + 1'b1;
            end
        end
    end

    // per-byte outputs, low byte at the low index
    generate
        for (g = 0; g < LANES; g = g + 1) begin : outs
            assign rxData[8*g +: 8]  = outWord[UW*g +: 8];
            assign ctrlDetect[g]     = outWord[UW*g + 8];
            assign codeErrDetect[g]  = outWord[UW*g + 9];
            assign dispErr[g]        = outWord[UW*g + 10];
            assign runningDispNeg[g] = outWord[UW*g + 11];
        end
    endgenerate

    // interrupt events
    assign irqEvent[`IRQ_CODE]  = codeValid & (|laneCodeErr);
    assign irqEvent[`IRQ_DISP]  = codeValid & (|laneDispErr);
    assign irqEvent[`IRQ_OVF]   = codeValid & fifoFull;
    assign irqEvent[`IRQ_FOUND] = |(orderFound & ~foundPrev);

endmodule

`default_nettype wire

// ===== verification/rx_pcs_monitor.sv
// checker bound to the receive back end ports
`timescale 1ns/1ps
`default_nettype none
module rx_pcs_monitor #(
    parameter NUM_CH  = 1,
    parameter BYTES   = 2,
    parameter FIFO_AW = 3
) (
    input wire                    clk_sys,
    input wire                    sys_rst,
    input wire                    avs_read,
    input wire                    avs_write,
    input wire                    avs_waitrequest,
    input wire                    codeValid,
    input wire [NUM_CH-1:0]       orderRestart,
    input wire [NUM_CH-1:0]       orderFound,
    input wire                    readReady,
    input wire                    dataValid,
    input wire [NUM_CH*BYTES-1:0] codeErrDetect,
    input wire [NUM_CH*BYTES-1:0] dispErr,
    input wire                    fifoError
);
    localparam [FIFO_AW:0] DEPTH = 1 << FIFO_AW;
    reg  [FIFO_AW:0] fill;
    wire             push = codeValid && (fill != DEPTH);
    wire             pop  = readReady && (fill != 0);
    // words held in the fifo
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            fill <= {(FIFO_AW+1){1'b0}};
        end else begin
            fill <= fill + {{FIFO_AW{1'b0}}, push} - {{FIFO_AW{1'b0}}, pop};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_err_pair;
        (dispErr & ~codeErrDetect) == {(NUM_CH*BYTES){1'b0}};
    endproperty
    a_err_pair: assert property (p_err_pair)
        else $error("disparity error without error detect");
    property p_fifo_err;
        fifoError == ((fill == 0) || (fill == DEPTH));
    endproperty
    a_fifo_err: assert property (p_fifo_err)
        else $error("fifo error flag disagrees with fill");
    property p_pop_answer;
        dataValid == $past(pop);
    endproperty
    a_pop_answer: assert property (p_pop_answer)
        else $error("data valid without a pop");
    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("no wait in first bus cycle");
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("more than one wait cycle");
    property p_restart;
        $rose(orderRestart[0]) |-> ##[2:4] !orderFound[0];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not clear found");
    property p_found_hold;
        $fell(orderFound[0]) |-> $past(orderRestart[0], 3);
    endproperty
    a_found_hold: assert property (p_found_hold)
        else $error("found dropped without restart");
    property p_found_cause;
        $rose(orderFound[0]) |-> $past(codeValid);
    endproperty
    a_found_cause: assert property (p_found_cause)
        else $error("found rose without a word");
    c_found: cover property ($rose(orderFound[0]));
    c_full: cover property ((fill == DEPTH) && codeValid);
    c_disp: cover property (dataValid && dispErr[0]);
endmodule
bind rx_pcs_decode_order_fifo rx_pcs_monitor #(
    .NUM_CH(NUM_CH), .BYTES(BYTES), .FIFO_AW(FIFO_AW)
) i_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .codeValid(codeValid), .orderRestart(orderRestart),
    .orderFound(orderFound), .readReady(readReady),
    .dataValid(dataValid), .codeErrDetect(codeErrDetect),
    .dispErr(dispErr), .fifoError(fifoError)
);
`default_nettype wire

// ===== verification/fabric_sink_model.sv
// fabric logic taking words out of the receive fifo
`timescale 1ns/1ps
`default_nettype none
module fabric_sink_model (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        enable,
    input  wire logic        slow,
    input  wire logic        dataValid,
    input  wire logic [15:0] rxData,
    input  wire logic [1:0]  ctrlDetect,
    input  wire logic [1:0]  codeErrDetect,
    input  wire logic [1:0]  dispErr,
    input  wire logic [1:0]  runningDispNeg,
    output var  logic        readReady
);
    logic [23:0] words [0:15];
    int          count;
    logic        phase;
    // pull every cycle or every other; same clock as the writer
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            readReady <= 1'b0;
            count <= 0;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            readReady <= enable && (!slow || phase);
            if (dataValid) begin
                words[count[3:0]] <= {runningDispNeg, dispErr,
                                      codeErrDetect, ctrlDetect, rxData};
                count <= count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/rx_pcs_decode_order_fifo_tb_top.sv
// bench for the receive back end with a fabric sink
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rx_pcs_decode_order_fifo_tb_top;
    localparam [9:0] K285N = 10'b0011111010;
    localparam [9:0] K285P = 10'b1100000101;
    localparam [9:0] D215  = 10'b1010101010;
    localparam [9:0] D000P = 10'b0110001011;
    localparam [9:0] D000N = 10'b1001110100;
    localparam [9:0] BADCG = 10'b1111000100;
    logic        clk_sys, sys_rst, avsRead, avsWrite, avsWaitrequest, irq;
    logic [4:0]  avsAddress;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [19:0] codeIn;
    logic        codeValid, readReady, dataValid, fifoError;
    logic [0:0]  orderRestart, orderFound;
    logic [15:0] rxData;
    logic [1:0]  ctrlDetect, codeErrDetect, dispErr, runningDispNeg;
    logic        sinkOn, sinkSlow;
    int          fails, checked;
    logic [4:0]  regA [4] = '{5'h00, 5'h04, 5'h10, 5'h14};
    logic [31:0] regE [4] = '{32'h0, 32'h1bc, 32'h0, 32'h0};
    logic [3:0]  ctl [5] = '{4'h0, 4'h8, 4'h2, 4'h4, 4'h1};
    logic [2:0]  src [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h0};
    rx_pcs_decode_order_fifo i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .irq(irq), .codeIn(codeIn), .codeValid(codeValid),
        .orderRestart(orderRestart), .orderFound(orderFound),
        .readReady(readReady), .dataValid(dataValid), .rxData(rxData),
        .ctrlDetect(ctrlDetect), .codeErrDetect(codeErrDetect),
        .dispErr(dispErr), .runningDispNeg(runningDispNeg),
        .fifoError(fifoError));
    fabric_sink_model i_sink (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .enable(sinkOn), .slow(sinkSlow), .dataValid(dataValid),
        .rxData(rxData), .ctrlDetect(ctrlDetect),
        .codeErrDetect(codeErrDetect), .dispErr(dispErr),
        .runningDispNeg(runningDispNeg), .readReady(readReady));
    // group written abcdeifghj, sent a first
    function automatic [9:0] grp(input [9:0] s);
        for (int k = 0; k < 10; k++) grp[k] = s[9-k];
    endfunction
    task automatic bus(input bit wr, input [4:0] a, input [31:0] wd);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= wd;
        avsRead <= !wr;
        avsWrite <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 50);
        rd = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) fails++;
        @(posedge clk_sys);
    endtask
    task automatic push(input [9:0] lo, input [9:0] hi);
        codeIn <= {grp(hi), grp(lo)};
        codeValid <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        codeValid <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wait_cnt(input int k);
        for (int n = 0; n < 100 && i_sink.count < k; n++) @(posedge clk_sys);
        `CHK("count", k, i_sink.count)
    endtask
    task test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watchdog against a hang
    initial begin
        #200000;
        fails++;
        test_done;
    end
    // main sequence
    initial begin
        {fails, checked} = 0;
        {sys_rst, avsRead, avsWrite, avsAddress, avsWritedata} = 1 << 39;
        {codeIn, codeValid, orderRestart, sinkOn, sinkSlow} = 0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("fifoError", 1'b1, fifoError)
        `CHK("width", 16, $bits(rxData))
        `CHK("flags", 2, $bits(dispErr))
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, regA[i], 32'h0);
            `CHK("reg", regE[i], rd)
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 5'h00, {28'h0, ctl[i]});
            bus(1'b0, 5'h08, 32'h0);
            `CHK("clksrc", src[i], rd[2:0])
        end
        push(K285N, D215);
        push(D000P, K285P);
        idle(1);
        `CHK("orderFound", 1'b1, orderFound)
        sinkOn <= 1'b1;
        wait_cnt(2);
        `CHK("word0", 24'h01b5bc, i_sink.words[0])
        `CHK("word1", 24'h82bc00, i_sink.words[1])
        orderRestart <= 1'b1;
        repeat (4) @(posedge clk_sys);
        orderRestart <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("orderFound", 1'b0, orderFound)
        push(K285N, D215);
        idle(1);
        `CHK("orderFound", 1'b1, orderFound)
        wait_cnt(3);
        sinkOn <= 1'b0;
        idle(2);
        for (int i = 0; i < 9; i++) push(D215, D215);
        idle(1);
        `CHK("fifoError", 1'b1, fifoError)
        bus(1'b0, 5'h08, 32'h0);
        `CHK("full", 2'b01, rd[4:3])
        bus(1'b0, 5'h0c, 32'h0);
        `CHK("ovf", 1'b1, rd[2])
        `CHK("irq", 1'b0, irq)
        bus(1'b1, 5'h10, 32'h4);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, 5'h0c, 32'h4);
        `CHK("irq", 1'b0, irq)
        sinkSlow <= 1'b1;
        sinkOn <= 1'b1;
        wait_cnt(11);
        `CHK("fifoError", 1'b1, fifoError)
        for (int i = 3; i < 11; i++)
            `CHK("word", 24'h00b5b5, i_sink.words[i])
        sinkSlow <= 1'b0;
        push(D000N, D215);
        push(BADCG, D215);
        idle(1);
        wait_cnt(13);
        `CHK("disp", 4'b0101, i_sink.words[11][21:18])
        `CHK("code", 4'b0001, i_sink.words[12][21:18])
        bus(1'b0, 5'h0c, 32'h0);
        `CHK("errbits", 2'b11, rd[1:0])
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("rstvals", 3'b100, {fifoError, orderFound, irq})
        push(D215, K285N);
        push(D215, D215);
        idle(1);
        `CHK("orderFound", 1'b1, orderFound)
        wait_cnt(2);
        `CHK("swap", 24'h01b5bc, i_sink.words[1])
        test_done;
    end
endmodule
`default_nettype wire
